/* pkg/dcc_pkg.sv */
`default_nettype none
package dcc_pkg;

    // consistency classification
    localparam logic [7:0]  DCC_TELEGRAM_MAX   = 8'h7a;
    localparam logic [7:0]  DCC_WORD_AREA_LEN  = 8'h02;

    // command channel answers
    localparam logic [15:0] DCC_UNKNOWN_VALUE  = 16'h0200;
    localparam logic [7:0]  DCC_UNKNOWN_LEN    = 8'h02;
    localparam logic [7:0]  DCC_SYSERR_CODE    = 8'h7f;
    localparam logic [7:0]  DCC_SYSERR_LEN     = 8'h0a;
    localparam logic [15:0] DCC_SYSERR_VALUE   = 16'h0000;

    // pacing of the data transfer list
    localparam logic [1:0]  DCC_LIST_EVERY     = 2'h3;
    localparam logic [1:0]  DCC_LIST_CNT_RST   = 2'h0;

    // reset values
    localparam logic [7:0]  DCC_DIAG_CNT_RST   = 8'h00;
    localparam logic [2:0]  DCC_SYNC_RST       = 3'h7;

    // position of the host pins in the synchroniser vector
    localparam int          DCC_PIN_CS         = 0;
    localparam int          DCC_PIN_WR         = 1;
    localparam int          DCC_PIN_RD         = 2;

    typedef enum logic [1:0] {
        DCC_CONS_NONE,
        DCC_CONS_BUFFERED,
        DCC_CONS_SHORT,
        DCC_CONS_LONG
    } dcc_cons_t;

    typedef struct packed {
        logic wr;
        logic rd;
    } dcc_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_message;
        logic [7:0]  code;
        logic [7:0]  len;
        logic [15:0] value;
    } dcc_resp_t;

endpackage
`default_nettype wire

/* core/dcc_cons_classify.sv */
`timescale 1ns/100ps
`default_nettype none
module dcc_cons_classify #(
    parameter int LEN_W = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [LEN_W-1:0] telegram_len,
    input  wire logic             consistent,
    input  wire logic [LEN_W-1:0] longest_area,
    input  wire logic [LEN_W-1:0] cons_limit,
    input  wire logic             word_cons,
    output var  dcc_pkg::dcc_cons_t cons_type
);
    logic                         fits;
    logic                         area_ok;
    dcc_pkg::dcc_cons_t           cons_type_next;

    assign fits    = telegram_len <= LEN_W'(dcc_pkg::DCC_TELEGRAM_MAX);
    assign area_ok = longest_area <= cons_limit;

    always_comb begin
        if (!consistent) begin
            cons_type_next = fits ? dcc_pkg::DCC_CONS_NONE
                                  : dcc_pkg::DCC_CONS_BUFFERED;
        end else if (fits && (area_ok || word_cons)) begin
            cons_type_next = dcc_pkg::DCC_CONS_SHORT;
        end else begin
            cons_type_next = dcc_pkg::DCC_CONS_LONG;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cons_type <= dcc_pkg::DCC_CONS_NONE;
        end else begin
            cons_type <= cons_type_next;
        end
    end

    // short only within the length limit
    short_len_a: assert property (@(posedge core_clk) disable iff (!rstn)
        consistent && telegram_len > LEN_W'(dcc_pkg::DCC_TELEGRAM_MAX)
        |=> cons_type == dcc_pkg::DCC_CONS_LONG)
        else $error("oversize consistent telegram not long");
endmodule
`default_nettype wire

/* core/dcc_consistency_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module dcc_consistency_ctrl #(
    parameter int LEN_W  = 8,
    parameter int DIAG_W = 8
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // host pins, asynchronous to core_clk
    input  wire logic              host_chip_select_n,
    input  wire logic              host_consistent_write_req_n,
    input  wire logic              host_consistent_read_req_n,
    output logic                   host_ready,
    output logic                   host_consistency_ack_n,
    output logic                   engine_conflict_flag,
    // protocol engine, same clock
    input  wire logic              engine_access,
    input  wire logic              engine_consistent_read,
    input  wire logic              engine_consistent_write,
    output logic                   engine_ready,
    // diagnostics
    input  wire logic              diag_update_done,
    input  wire logic              data_cycle_done,
    output logic [DIAG_W-1:0]      diag_count,
    output logic                   sys_diag_refresh,
    output logic                   transfer_list_write,
    // command channel
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_code,
    input  wire logic              cmd_known,
    input  wire logic              sys_err_report,
    output dcc_pkg::dcc_resp_t     resp,
    // consistency classification
    input  wire logic [LEN_W-1:0]  telegram_len,
    input  wire logic              consistent,
    input  wire logic [LEN_W-1:0]  longest_area,
    input  wire logic [LEN_W-1:0]  cons_limit,
    input  wire logic              word_cons,
    output dcc_pkg::dcc_cons_t     cons_type
);
    logic [2:0]         sync1_reg;
    logic [2:0]         sync2_reg;
    logic               host_cs;
    dcc_pkg::dcc_req_t  hreq;
    dcc_pkg::dcc_req_t  ereq;
    logic               hreq_any;
    logic               ereq_any;
    logic               conf;
    logic               host_ack;
    logic               host_ack_next;
    logic               eng_own_reg;
    logic               eng_own_next;
    logic               eng_stall;
    logic [1:0]         list_cnt_reg;

    function automatic logic req_conflict(dcc_pkg::dcc_req_t a,
                                          dcc_pkg::dcc_req_t b);
        req_conflict = (a.wr && b.rd) || (a.rd && b.wr);
    endfunction

    // host pins go through two flops; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sync1_reg <= dcc_pkg::DCC_SYNC_RST;
            sync2_reg <= dcc_pkg::DCC_SYNC_RST;
        end else begin
            sync1_reg <= {host_consistent_read_req_n,
                          host_consistent_write_req_n,
                          host_chip_select_n};
            sync2_reg <= sync1_reg;
        end
    end

    assign host_cs  = !sync2_reg[dcc_pkg::DCC_PIN_CS];
    assign hreq.wr  = !sync2_reg[dcc_pkg::DCC_PIN_WR];
    assign hreq.rd  = !sync2_reg[dcc_pkg::DCC_PIN_RD];
    // engine strobes announce its consistent transfer
    assign ereq.wr  = engine_consistent_write;
    assign ereq.rd  = engine_consistent_read;
    // a side never raises both, so an either-bit test suffices
    assign hreq_any = hreq.wr || hreq.rd;
    assign ereq_any = ereq.wr || ereq.rd;
    assign conf     = req_conflict(hreq, ereq);
    assign host_ack = !host_consistency_ack_n;

    // engine wins a tie, host only granted free of conflict
    // a held acknowledge is never taken back early
    // drop once the request is gone
    assign host_ack_next = hreq_any
                         && (host_ack || !(ereq_any && conf));

    // engine keeps its access while its strobe stays up
    // engine waits while the host holds a conflicting grant
    assign eng_own_next  = ereq_any
                         && (eng_own_reg || !(host_ack && conf));
    assign eng_stall     = ereq_any && !eng_own_next;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            host_consistency_ack_n <= 1'b1;
        end else begin
            host_consistency_ack_n <= !host_ack_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            eng_own_reg <= 1'b0;
        end else begin
            eng_own_reg <= eng_own_next;
        end
    end

    // plain engine accesses are never held here
    // short consistency lets the engine go straight to memory
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            engine_ready <= 1'b0;
        end else begin
            engine_ready <= engine_access && !eng_stall;
        end
    end

    // flag the host while the engine is locked out
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            engine_conflict_flag <= 1'b0;
        end else begin
            engine_conflict_flag <= eng_stall;
        end
    end

    // a host access with a consistent request waits for the acknowledge; other accesses do not
    // a long hold here starves the engine; kept short by the host
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            host_ready <= 1'b0;
        end else begin
            host_ready <= host_cs && (!hreq_any || host_ack);
        end
    end

    // the host compares this count across its reads
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            diag_count <= DIAG_W'(dcc_pkg::DCC_DIAG_CNT_RST);
        end else if (diag_update_done) begin
            diag_count <= diag_count + DIAG_W'(1);
        end
    end

    // diagnostic area every cycle, list every third
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            list_cnt_reg <= dcc_pkg::DCC_LIST_CNT_RST;
        end else if (data_cycle_done) begin
            if (list_cnt_reg == dcc_pkg::DCC_LIST_EVERY - 2'h1) begin
                list_cnt_reg <= dcc_pkg::DCC_LIST_CNT_RST;
            end else begin
                list_cnt_reg <= list_cnt_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sys_diag_refresh    <= 1'b0;
            transfer_list_write <= 1'b0;
        end else begin
            sys_diag_refresh    <= data_cycle_done;
            transfer_list_write <= data_cycle_done
                && list_cnt_reg == dcc_pkg::DCC_LIST_EVERY - 2'h1;
        end
    end

    // system error message takes precedence; an unknown command in the
    // same cycle is dropped here and gets no answer from this block
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            resp <= '0;
        end else if (sys_err_report) begin
            resp.valid      <= 1'b1;
            resp.is_message <= 1'b1;
            resp.code       <= dcc_pkg::DCC_SYSERR_CODE;
            resp.len        <= dcc_pkg::DCC_SYSERR_LEN;
            resp.value      <= dcc_pkg::DCC_SYSERR_VALUE;
        end else if (cmd_valid && !cmd_known) begin
            resp.valid      <= 1'b1;
            resp.is_message <= 1'b0;
            resp.code       <= cmd_code;
            resp.len        <= dcc_pkg::DCC_UNKNOWN_LEN;
            resp.value      <= dcc_pkg::DCC_UNKNOWN_VALUE;
        end else begin
            resp.valid      <= 1'b0;
        end
    end

    // word/byte consistency lives in the memory controller
    // area membership is not checked, the type alone decides
    // one direction per byte is kept by software
    dcc_cons_classify #(
        .LEN_W        (LEN_W)
    ) u_classify (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .telegram_len (telegram_len),
        .consistent   (consistent),
        .longest_area (longest_area),
        .cons_limit   (cons_limit),
        .word_cons    (word_cons),
        .cons_type    (cons_type)
    );

    default clocking dcc_cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence host_clean_req;
        hreq_any && !(ereq_any && conf) && host_consistency_ack_n;
    endsequence

    sequence engine_locked;
        ereq_any && conf && host_ack && !eng_own_reg;
    endsequence

    ack_grant_a: assert property (host_clean_req
        |=> !host_consistency_ack_n)
        else $error("clean host request not acknowledged");

    ack_drop_a: assert property (!hreq_any |=> host_consistency_ack_n)
        else $error("acknowledge held after request dropped");

    engine_first_a: assert property (
        hreq_any && ereq_any && conf && host_consistency_ack_n
        |=> host_consistency_ack_n)
        else $error("host granted against conflicting engine");

    no_preempt_a: assert property (host_ack && hreq_any && conf
        && !eng_own_reg |=> host_ack && !eng_own_reg)
        else $error("host grant preempted");

    engine_stall_a: assert property (engine_locked and engine_access
        |=> !engine_ready && engine_conflict_flag)
        else $error("engine not stalled in conflict");

    conflict_flag_a: assert property (!ereq_any |=> !engine_conflict_flag)
        else $error("conflict flag without engine request");

    plain_engine_a: assert property (engine_access && !ereq_any
        |=> engine_ready)
        else $error("plain engine access held");

    host_wait_a: assert property (host_cs && hreq_any && !host_ack
        |=> !host_ready)
        else $error("host ready before acknowledge");

    host_normal_a: assert property (host_cs && host_ack
        |=> host_ready)
        else $error("granted host access stalled");

    diag_inc_a: assert property (diag_update_done
        |=> diag_count == $past(diag_count) + DIAG_W'(1))
        else $error("diagnosis counter not incremented");

    list_pace_a: assert property (transfer_list_write
        |-> $past(list_cnt_reg) == dcc_pkg::DCC_LIST_EVERY - 2'h1)
        else $error("transfer list written off pace");

    unknown_cmd_a: assert property (cmd_valid && !cmd_known
        && !sys_err_report |=> resp.valid
        && resp.value == dcc_pkg::DCC_UNKNOWN_VALUE
        && resp.code == $past(cmd_code))
        else $error("unknown command answer wrong");

    sys_err_a: assert property (sys_err_report |=> resp.is_message
        && resp.code == dcc_pkg::DCC_SYSERR_CODE
        && resp.len == dcc_pkg::DCC_SYSERR_LEN)
        else $error("system error message wrong");
endmodule
`default_nettype wire

/* tb/dcc_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
// protocol engine side: one burst of words per start pulse
module dcc_engine_model (
    input  wire logic       core_clk,
    input  wire logic       start,
    input  wire logic [1:0] kind,
    input  wire logic [3:0] words,
    input  wire logic       engine_ready,
    output logic            engine_access,
    output logic            engine_consistent_read,
    output logic            engine_consistent_write,
    output logic            busy
);
    logic [7:0] served = 8'h00;
    logic [7:0] target = 8'h00;
    initial begin
        engine_access = 1'b0;
        engine_consistent_read = 1'b0;
        engine_consistent_write = 1'b0;
        busy = 1'b0;
    end
    // a word completes only on an edge with ready high
    always @(posedge core_clk) begin
        if (engine_access && engine_ready) begin
            served <= served + 8'h01;
        end
    end
    always @(negedge core_clk) begin
        if (!busy && start) begin
            busy <= 1'b1;
            target <= served + {4'h0, words};
            engine_access <= 1'b1;
            engine_consistent_read <= (kind == 2'h1);
            engine_consistent_write <= (kind == 2'h2);
        end else if (busy && served == target) begin
            busy <= 1'b0;
            engine_access <= 1'b0;
            engine_consistent_read <= 1'b0;
            engine_consistent_write <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/dpram_consistency_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dpram_consistency_control_tb_top;
    logic core_clk = 1'b0, rstn = 1'b0;
    logic cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    logic e_start = 1'b0, e_acc, e_rd, e_wr, e_busy;
    logic [1:0] e_kind = 2'h0;
    logic [3:0] e_words = 4'h1;
    logic diag_upd = 1'b0, dcyc = 1'b0, cmd_valid = 1'b0, cmd_known = 1'b0;
    logic sys_err = 1'b0, cons = 1'b0, wcons = 1'b0;
    logic [7:0] cmd_code = 8'h00, tlen = 8'h00, area = 8'h00, lim = 8'h00;
    logic host_ready, ack_n, conflict, engine_ready, refresh, tlw;
    logic [7:0] diag_count;
    dcc_pkg::dcc_resp_t resp;
    dcc_pkg::dcc_cons_t ctype;
    integer seed = 32'hbcf2c4cc;
    logic [31:0] r;
    logic [7:0] exp_cnt = 8'h00, old_cnt;
    int ncyc = 0, miscompares = 0, checked = 0, cycles = 0;

    always #25 core_clk = ~core_clk;

    dcc_consistency_ctrl #(.LEN_W(8), .DIAG_W(8)) u_dut (
        .core_clk(core_clk), .rstn(rstn), .host_chip_select_n(cs_n),
        .host_consistent_write_req_n(wr_n), .host_consistent_read_req_n(rd_n),
        .host_ready(host_ready), .host_consistency_ack_n(ack_n),
        .engine_conflict_flag(conflict), .engine_access(e_acc),
        .engine_consistent_read(e_rd), .engine_consistent_write(e_wr),
        .engine_ready(engine_ready), .diag_update_done(diag_upd),
        .data_cycle_done(dcyc), .diag_count(diag_count),
        .sys_diag_refresh(refresh), .transfer_list_write(tlw),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_known(cmd_known),
        .sys_err_report(sys_err), .resp(resp), .telegram_len(tlen),
        .consistent(cons), .longest_area(area), .cons_limit(lim),
        .word_cons(wcons), .cons_type(ctype));

    dcc_engine_model u_eng (
        .core_clk(core_clk), .start(e_start), .kind(e_kind), .words(e_words),
        .engine_ready(engine_ready), .engine_access(e_acc),
        .engine_consistent_read(e_rd), .engine_consistent_write(e_wr),
        .busy(e_busy));

    task automatic results();
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // tests need well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            $display("[ERR] %0t run did not finish", $time);
            results();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait; the caller compares afterwards
    task automatic wait_bit(ref logic s, input logic v);
        for (int i = 0; i < 16 && s !== v; i++) @(negedge core_clk);
    endtask
    task automatic eng(input logic [1:0] k, input logic [3:0] w);
        e_kind <= k;
        e_words <= w;
        e_start <= 1'b1;
        @(negedge core_clk);
        e_start <= 1'b0;
    endtask
    function automatic dcc_pkg::dcc_cons_t exp_type(input logic [7:0] l,
        input logic c, input logic [7:0] a, input logic [7:0] m,
        input logic w);
        if (!c) return (l <= 8'h7a) ? dcc_pkg::DCC_CONS_NONE
                                   : dcc_pkg::DCC_CONS_BUFFERED;
        if (l > 8'h7a) return dcc_pkg::DCC_CONS_LONG;
        return (w || a <= m) ? dcc_pkg::DCC_CONS_SHORT : dcc_pkg::DCC_CONS_LONG;
    endfunction

    initial begin
        cyc(5);
        chk_vec({host_ready, ack_n, conflict, engine_ready, diag_count}, 34'h400);
        chk_vec(resp, 34'h0);
        cyc(1);
        rstn = 1'b1;
        cyc(2);
        wr_n = 1'b0;
        wait_bit(ack_n, 1'b0);
        chk_bit(ack_n, 1'b0);
        cs_n = 1'b0;
        cyc(3);
        chk_bit(host_ready, 1'b1);
        eng(2'h1, 4'h2);
        cyc(3);
        chk_bit(engine_ready, 1'b0);
        chk_bit(conflict, 1'b1);
        chk_bit(ack_n, 1'b0);
        wr_n = 1'b1;
        cs_n = 1'b1;
        wait_bit(e_busy, 1'b0);
        chk_bit(e_busy, 1'b0);
        chk_bit(conflict, 1'b0);
        chk_bit(ack_n, 1'b1);
        for (int i = 0; i < 3; i++) begin
            if (i == 0) rd_n = 1'b0;
            else wr_n = 1'b0;
            wait_bit(ack_n, 1'b0);
            eng((i == 0) ? 2'h1 : ((i == 1) ? 2'h2 : 2'h0), 4'h3);
            cyc(2);
            chk_bit(conflict, 1'b0);
            chk_bit(engine_ready, 1'b1);
            wait_bit(e_busy, 1'b0);
            rd_n = 1'b1;
            wr_n = 1'b1;
            cyc(4);
        end
        for (int i = 0; i < 2; i++) begin
            if (i == 0) eng(2'h2, 4'ha);
            cyc(i == 0 ? 2 : 0);
            rd_n = 1'b0;
            cs_n = 1'b0;
            if (i == 1) eng(2'h2, 4'h8);
            cyc(4);
            chk_bit(ack_n, 1'b1);
            chk_bit(host_ready, 1'b0);
            chk_bit(conflict, 1'b0);
            wait_bit(e_busy, 1'b0);
            wait_bit(ack_n, 1'b0);
            chk_bit(ack_n, 1'b0);
            cyc(2);
            chk_bit(host_ready, 1'b1);
            rd_n = 1'b1;
            cs_n = 1'b1;
            cyc(4);
        end
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            diag_upd = r[0];
            dcyc = r[1];
            old_cnt = diag_count;
            cyc(1);
            chk_bit(diag_count != old_cnt, diag_upd);
            if (diag_upd) exp_cnt++;
            if (dcyc) ncyc++;
            chk_vec(34'(diag_count), 34'(exp_cnt));
            chk_bit(refresh, dcyc);
            chk_bit(tlw, dcyc && (ncyc % 3 == 0));
        end
        diag_upd = 1'b0;
        dcyc = 1'b0;
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            {cmd_valid, cmd_known, cmd_code} = {r[0], r[1], r[15:8]};
            sys_err = (r[4:2] == 3'h0);
            cyc(1);
            if (sys_err) chk_vec(resp, {2'h3, 8'h7f, 8'h0a, 16'h0000});
            else if (cmd_valid && !cmd_known)
                chk_vec({resp.is_message, resp.valid, resp.code, resp.len,
                         resp.value},
                        {2'h1, cmd_code, 8'h02, 16'h0200});
            else chk_bit(resp.valid, 1'b0);
        end
        {cmd_valid, sys_err} = 2'h0;
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            tlen = r[0] ? (8'h77 + {5'h0, r[10:8]}) : r[15:8];
            {cons, wcons, lim} = {r[1], r[2], r[31:24]};
            area = r[3] ? lim : r[23:16];
            cyc(1);
            chk_vec(34'(ctype), 34'(exp_type(tlen, cons, area, lim, wcons)));
        end
        results();
    end
endmodule
`default_nettype wire
